/* File: fault_status_interrupt_flags.sv */
// fault latches, live status, interrupt flags and serial register access
`default_nettype none

// Functional notes
// - thermal latch flag in latch register bit 4 sets after thermal shutdown
// - channel 1..4 latch-off flags in bits 0..3 set on channel latch-off
// - latch flags stay set; write one clears only once fault is gone
// - read-only live register shows channel power-good and button state
// - live bits 0..3 follow channel power-good levels, zero after reset
// - live bit 6 shows debounced button press, only in switch mode
// - event register holds overheat, low supply and power-good failure
// - any unmasked event flag drives the interrupt pin low
// - each event has a mask bit; zero blocks it, one passes it
// - event bit 6 sets on a button press in switch mode
// - event bit 5 sets when junction overheat warning is raised
// - event bit 4 sets when input supply falls below threshold
// - event bits 0..3 set on power-good failure of channels 1..4
// - power-good failures raise no flag during init or normal shutdown
// - event flags stay set after their cause disappears
// - writing one to an event bit clears that flag once its cause is gone
// - all event flags with no active cause clear while every channel enable is low
module fault_status_interrupt_flags
  import fault_flags_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                scl,
  input  wire logic                sda_in,
  output var  logic                sda_out,
  output var  logic                sda_oe,
  input  wire logic [CHANNELS-1:0] power_good,
  input  wire logic [CHANNELS-1:0] channel_enable_pins,
  input  wire logic                manual_button_n,
  input  wire logic                thermal_shutdown,
  input  wire logic [CHANNELS-1:0] chan_latchoff,
  input  wire logic                overheat_warning,
  input  wire logic                low_supply_warning,
  input  wire logic                power_switch_mode,
  input  wire logic                device_init,
  input  wire logic                normal_shutdown,
  output var  logic                interrupt_n
);

  // ********************************************************************
  // pin synchronisation
  // ********************************************************************
  logic [20:0]         raw_pins;
  logic [20:0]         sync_pins;
  logic                scl_s;
  logic                sda_s;
  logic [CHANNELS-1:0] good_s;
  logic [CHANNELS-1:0] enable_s;
  logic                button_n_s;
  logic                thermal_s;
  logic [CHANNELS-1:0] latchoff_s;
  logic                overheat_s;
  logic                low_supply_s;
  logic                switch_mode_s;
  logic                init_s;
  logic                shutdown_s;

  assign raw_pins = {scl, sda_in, power_good, channel_enable_pins,
                     manual_button_n, thermal_shutdown, chan_latchoff,
                     overheat_warning, low_supply_warning,
                     power_switch_mode, device_init, normal_shutdown};

  pin_sync #(
    .WIDTH       (21),
    .RESET_VALUE (PIN_SYNC_RESET)
  ) u_pin_sync (
    .clock (clock),
    .rst   (rst),
    .pins  (raw_pins),
    .level (sync_pins)
  );

  assign {scl_s, sda_s, good_s, enable_s, button_n_s, thermal_s,
          latchoff_s, overheat_s, low_supply_s, switch_mode_s,
          init_s, shutdown_s} = sync_pins;

  // ********************************************************************
  // button debounce
  // ********************************************************************
  logic       button_pressed;
  logic [3:0] debounce_count;
  logic       button_differs;
  logic       button_settled;
  logic       button_live_state;
  logic       button_press_event;

  assign button_differs = (~button_n_s) != button_pressed;
  assign button_settled = debounce_count == DEBOUNCE_COUNT - 4'h1;
  // the live bit only carries meaning when the switch function is chosen
  assign button_live_state = button_pressed & switch_mode_s;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      button_pressed <= 1'b0;
      debounce_count <= 4'h0;
    end
    else if (!button_differs)
      debounce_count <= 4'h0;
    else if (button_settled)
    begin
      button_pressed <= ~button_pressed;
      debounce_count <= 4'h0;
    end
    else
      debounce_count <= debounce_count + 4'h1;
  end

  assign button_press_event = button_differs & button_settled
                            & ~button_pressed & switch_mode_s;

  // ********************************************************************
  // serial register link
  // ********************************************************************
  link_state_type link_state;
  logic           scl_prev;
  logic           sda_prev;
  logic [3:0]     bit_count;
  logic [7:0]     rx_shift;
  logic [7:0]     tx_shift;
  logic           got_addr;
  logic           got_ptr;
  logic           read_mode;
  logic [7:0]     pointer;
  logic           reg_wr;
  logic [7:0]     reg_wr_addr;
  logic [7:0]     reg_wr_data;
  logic [7:0]     read_data;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_seen;
  logic           stop_seen;
  logic           byte_done;
  logic           addr_match;

  assign scl_rise   = scl_s & ~scl_prev;
  assign scl_fall   = ~scl_s & scl_prev;
  assign start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_seen  = scl_s & scl_prev & ~sda_prev & sda_s;
  assign byte_done  = scl_fall & (bit_count == 4'h8);
  assign addr_match = rx_shift[7:1] == DEVICE_ADDRESS;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      sda_out  <= 1'b0;
    end
    else
    begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
      // open drain: only ever pulls low
      sda_out  <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      link_state  <= LINK_IDLE;
      bit_count   <= 4'h0;
      rx_shift    <= 8'h00;
      tx_shift    <= 8'h00;
      got_addr    <= 1'b0;
      got_ptr     <= 1'b0;
      read_mode   <= 1'b0;
      pointer     <= 8'h00;
      sda_oe      <= 1'b0;
      reg_wr      <= 1'b0;
      reg_wr_addr <= 8'h00;
      reg_wr_data <= 8'h00;
    end
    else
    begin
      reg_wr <= 1'b0;
      if (stop_seen)
      begin
        link_state <= LINK_IDLE;
        sda_oe     <= 1'b0;
      end
      else if (start_seen)
      begin
        link_state <= LINK_RX;
        bit_count  <= 4'h0;
        got_addr   <= 1'b0;
        got_ptr    <= 1'b0;
        sda_oe     <= 1'b0;
      end
      else
        unique case (link_state)
          LINK_IDLE:
          begin
          end
          LINK_RX:
          begin
            if (scl_rise)
            begin
              rx_shift  <= {rx_shift[6:0], sda_s};
              bit_count <= bit_count + 4'h1;
            end
            else if (byte_done && !got_addr)
            begin
              got_addr   <= addr_match;
              read_mode  <= rx_shift[0];
              sda_oe     <= addr_match;
              link_state <= addr_match ? LINK_RX_ACK : LINK_IDLE;
            end
            else if (byte_done && !got_ptr)
            begin
              got_ptr    <= 1'b1;
              pointer    <= rx_shift;
              sda_oe     <= 1'b1;
              link_state <= LINK_RX_ACK;
            end
            else if (byte_done)
            begin
              reg_wr      <= 1'b1;
              reg_wr_addr <= pointer;
              reg_wr_data <= rx_shift;
              pointer     <= pointer + 8'h01;
              sda_oe      <= 1'b1;
              link_state  <= LINK_RX_ACK;
            end
          end
          LINK_RX_ACK:
          begin
            if (scl_fall)
            begin
              bit_count  <= 4'h0;
              tx_shift   <= read_data;
              sda_oe     <= read_mode & ~read_data[7];
              pointer    <= read_mode ? pointer + 8'h01 : pointer;
              link_state <= read_mode ? LINK_TX : LINK_RX;
            end
          end
          LINK_TX:
          begin
            if (scl_fall && bit_count == 4'h7)
            begin
              sda_oe     <= 1'b0;
              link_state <= LINK_TX_ACK;
            end
            else if (scl_fall)
            begin
              tx_shift  <= {tx_shift[6:0], 1'b0};
              sda_oe    <= ~tx_shift[6];
              bit_count <= bit_count + 4'h1;
            end
          end
          LINK_TX_ACK:
          begin
            // a not-acknowledge ends the read burst
            if (scl_rise && sda_s)
              link_state <= LINK_IDLE;
            else if (scl_fall)
            begin
              bit_count  <= 4'h0;
              tx_shift   <= read_data;
              sda_oe     <= ~read_data[7];
              pointer    <= pointer + 8'h01;
              link_state <= LINK_TX;
            end
          end
          default:
            link_state <= LINK_IDLE;
        endcase
    end
  end

  // ********************************************************************
  // flag banks and registers
  // ********************************************************************
  flag_bank_if #(.WIDTH(LATCH_WIDTH)) latch_bank ();
  flag_bank_if #(.WIDTH(EVENT_WIDTH)) event_bank ();

  sticky_flags #(.WIDTH(LATCH_WIDTH)) u_latch_flags (
    .clock (clock),
    .rst   (rst),
    .bank  (latch_bank)
  );

  sticky_flags #(.WIDTH(EVENT_WIDTH)) u_event_flags (
    .clock (clock),
    .rst   (rst),
    .bank  (event_bank)
  );

  logic [7:0]             event_mask;
  logic [CHANNELS-1:0]    good_prev;
  logic [LATCH_WIDTH-1:0] latch_fault;
  logic [CHANNELS-1:0]    good_fail;
  logic                   good_suppress;
  logic                   all_disabled;
  logic                   wr_latch;
  logic                   wr_event;
  logic                   wr_mask;
  logic [7:0]             live_status;
  logic                   irq_pending;

  assign wr_latch = reg_wr & (reg_wr_addr == LATCH_FLAGS_ADDR);
  assign wr_event = reg_wr & (reg_wr_addr == EVENT_FLAGS_ADDR);
  assign wr_mask  = reg_wr & (reg_wr_addr == EVENT_MASK_ADDR);

  assign latch_fault = {thermal_s, latchoff_s};
  assign latch_bank.set = latch_fault;
  // a write can only drop a flag whose fault has gone away
  assign latch_bank.clear = wr_latch
    ? reg_wr_data[LATCH_WIDTH-1:0] & ~latch_fault : '0;

  // expected power-good drops during bring-up or shutdown are ignored
  assign good_suppress = init_s | shutdown_s;
  assign good_fail = good_prev & ~good_s
                   & {CHANNELS{~good_suppress}};
  assign all_disabled = enable_s == '0;

  assign event_bank.set = {button_press_event,
                           overheat_s,
                           low_supply_s,
                           good_fail};
  assign event_bank.clear =
    (wr_event ? reg_wr_data[EVENT_WIDTH-1:0] : '0)
    | {EVENT_WIDTH{all_disabled}};

  assign live_status = {1'b0, button_live_state, 2'b00, good_s};

  assign read_data =
    (pointer == LATCH_FLAGS_ADDR) ? {3'h0, latch_bank.flags} :
    (pointer == LIVE_STATUS_ADDR) ? live_status :
    (pointer == EVENT_FLAGS_ADDR) ? {1'b0, event_bank.flags} :
    (pointer == EVENT_MASK_ADDR)  ? event_mask : READ_UNMAPPED;

  assign irq_pending = |(event_bank.flags
                         & event_mask[EVENT_WIDTH-1:0]);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      event_mask  <= EVENT_MASK_RESET;
      good_prev   <= '0;
      interrupt_n <= 1'b1;
    end
    else
    begin
      if (wr_mask)
        event_mask <= reg_wr_data;
      good_prev   <= good_s;
      interrupt_n <= ~irq_pending;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking chk_cb @(posedge clock);
  endclocking
  default disable iff (rst);

  irq_drive_a :
  assert property (irq_pending |=> !interrupt_n)
    else $error("interrupt not driven low for an unmasked flag");

  irq_release_a :
  assert property (!irq_pending |=> interrupt_n)
    else $error("interrupt held low with no unmasked flag");

  thermal_latch_a :
  assert property (thermal_s |=> latch_bank.flags[LATCH_THERMAL_BIT])
    else $error("thermal latch flag not set");

  chan_latch_a :
  assert property (latchoff_s[0] |=> latch_bank.flags[0])
    else $error("channel latch-off flag not set");

  latch_hold_a :
  assert property (latch_bank.flags[3] && latchoff_s[3]
                   |=> latch_bank.flags[3])
    else $error("latch flag cleared while fault present");

  live_good_a :
  assert property ($changed(good_s) |-> read_data[3:0] == good_s
                   || pointer != LIVE_STATUS_ADDR)
    else $error("live power-good bits do not follow the channels");

  button_press_a :
  assert property ($rose(button_pressed)
                   |-> $past(button_n_s, 1) == 1'b0
                    && $past(button_n_s, 8) == 1'b0)
    else $error("button press accepted before debounce time");

  good_quiet_a :
  assert property (good_suppress && event_bank.flags[3:0] == 4'h0
                   |=> event_bank.flags[3:0] == 4'h0)
    else $error("power-good flag raised while suppressed");

  event_sticky_a :
  assert property (event_bank.flags[EVENT_HEAT_BIT]
                   && !event_bank.clear[EVENT_HEAT_BIT]
                   |=> event_bank.flags[EVENT_HEAT_BIT])
    else $error("overheat flag dropped without a clear");

  event_clear_a :
  assert property (wr_event && reg_wr_data[EVENT_LOW_BIT]
                   && !low_supply_s |=> !event_bank.flags[EVENT_LOW_BIT])
    else $error("write of one did not clear low supply flag");

  all_off_a :
  assert property (all_disabled && event_bank.set == '0
                   |=> event_bank.flags == '0)
    else $error("flags not cleared with all channels disabled");

endmodule // fault_status_interrupt_flags

`default_nettype wire

/* File: fault_flags_pkg.sv */
// shared constants for the fault and interrupt flag block
`default_nettype none

package fault_flags_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [7:0] LATCH_FLAGS_ADDR = 8'h0C;
  localparam logic [7:0] LIVE_STATUS_ADDR = 8'h0D;
  localparam logic [7:0] EVENT_FLAGS_ADDR = 8'h0E;
  localparam logic [7:0] EVENT_MASK_ADDR  = 8'h0F;
  localparam logic [7:0] READ_UNMAPPED    = 8'h00;

  // ********************************************************************
  // field layout and reset values
  // ********************************************************************
  localparam int CHANNELS          = 4;
  localparam int LATCH_WIDTH       = 5;
  localparam int LATCH_THERMAL_BIT = 4;
  localparam int LIVE_BUTTON_BIT   = 6;
  localparam int EVENT_WIDTH       = 7;
  localparam int EVENT_LOW_BIT     = 4;
  localparam int EVENT_HEAT_BIT    = 5;
  localparam int EVENT_BUTTON_BIT  = 6;
  localparam logic [7:0] EVENT_MASK_RESET = 8'h00;
  // scl, sda and the button idle high; everything else idles low
  localparam logic [20:0] PIN_SYNC_RESET  = 21'h180400;

  // arbitrary bus address, not taken from any part
  localparam logic [6:0] DEVICE_ADDRESS = 7'h2A;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLOCK_PERIOD_PS    = 8000;
  localparam int BUTTON_DEBOUNCE_NS = 100;
  localparam logic [3:0] DEBOUNCE_COUNT = 4'((BUTTON_DEBOUNCE_NS * 1000
    + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);

  // ********************************************************************
  // serial link states
  // ********************************************************************
  typedef enum logic [4:0] {
    LINK_IDLE   = 5'b00001,
    LINK_RX     = 5'b00010,
    LINK_RX_ACK = 5'b00100,
    LINK_TX     = 5'b01000,
    LINK_TX_ACK = 5'b10000
  } link_state_type;

endpackage

`default_nettype wire

/* File: flag_bank_if.sv */
// set, clear and stored value of one bank of sticky flags
`default_nettype none

interface flag_bank_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] set;
  logic [WIDTH-1:0] clear;
  logic [WIDTH-1:0] flags;
  modport owner (input set, input clear, output flags);
  modport user  (output set, output clear, input flags);
endinterface

`default_nettype wire

/* File: pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`default_nettype none

module pin_sync
  import fault_flags_pkg::*;
#(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pins,
  output var  logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  // a bit moves only once stages two and three agree
  assign agree = ~(stage2 ^ stage3);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      level  <= RESET_VALUE;
    end
    else
    begin
      stage1 <= pins;
      stage2 <= stage1;
      stage3 <= stage2;
      level  <= (stage2 & agree) | (level & ~agree);
    end
  end

endmodule // pin_sync

`default_nettype wire

/* File: sticky_flags.sv */
// bank of sticky flags where a set beats a clear in the same cycle
`default_nettype none

module sticky_flags
  import fault_flags_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input  wire logic   clock,
  input  wire logic   rst,
  flag_bank_if.owner  bank
);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      bank.flags <= '0;
    else
      bank.flags <= (bank.flags & ~bank.clear) | bank.set;
  end

endmodule // sticky_flags

`default_nettype wire

/* File: bus_host.sv */
// two-wire bus host model for register reads and writes
`default_nettype none

module bus_host
  import fault_flags_pkg::*;
(
  input  wire logic clock,
  input  wire logic sda_line,
  output var  logic scl,
  output var  logic sda_rel
);
  timeunit 1ns;
  timeprecision 1ps;

  int ack_misses = 0;

  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // ****************************************************************
  // bit level: data moves a few clocks after scl falls so that the
  // device never sees scl and data change in the same cycle
  // ****************************************************************
  task automatic phase();
    repeat (8) @(posedge clock);
  endtask

  task automatic put_bit(input logic b);
    repeat (3) @(posedge clock);
    sda_rel <= b;
    phase();
    scl <= 1'b1;
    phase();
    scl <= 1'b0;
  endtask

  task automatic get_bit(output logic b);
    repeat (3) @(posedge clock);
    sda_rel <= 1'b1;
    phase();
    scl <= 1'b1;
    phase();
    b = sda_line;
    scl <= 1'b0;
  endtask

  task automatic start();
    repeat (3) @(posedge clock);
    sda_rel <= 1'b1;
    phase();
    scl <= 1'b1;
    phase();
    sda_rel <= 1'b0;
    phase();
    scl <= 1'b0;
  endtask

  task automatic stop();
    repeat (3) @(posedge clock);
    sda_rel <= 1'b0;
    phase();
    scl <= 1'b1;
    phase();
    sda_rel <= 1'b1;
    phase();
  endtask

  task automatic send_byte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--)
      put_bit(v[i]);
    get_bit(a);
    if (a !== 1'b0)
      ack_misses++;
  endtask

  // ****************************************************************
  // register access
  // ****************************************************************
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    start();
    send_byte({DEVICE_ADDRESS, 1'b0});
    send_byte(a);
    send_byte(d);
    stop();
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    start();
    send_byte({DEVICE_ADDRESS, 1'b0});
    send_byte(a);
    start();
    send_byte({DEVICE_ADDRESS, 1'b1});
    for (int i = 7; i >= 0; i--)
      get_bit(d[i]);
    put_bit(1'b1);
    stop();
  endtask
endmodule // bus_host

`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the fault and interrupt flag block
`default_nettype none

module testbench
  import fault_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock;
  logic       rst;
  logic       scl;
  logic       sda_host;
  logic       sda_out;
  logic       sda_oe;
  logic       sda_line;
  logic [3:0] pg;
  logic [3:0] en;
  logic [3:0] latchoff;
  logic       btn_n;
  logic       thermal;
  logic       heat;
  logic       low;
  logic       switch_mode;
  logic       init;
  logic       shut;
  logic       interrupt_n;
  int         n_fail = 0;
  int         comparisons = 0;
  int         cycles = 0;

  // open-drain data line with pull-up
  assign sda_line = sda_host & ~(sda_oe & ~sda_out);

  fault_status_interrupt_flags dut (
    .clock(clock), .rst(rst), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .power_good(pg),
    .channel_enable_pins(en), .manual_button_n(btn_n),
    .thermal_shutdown(thermal), .chan_latchoff(latchoff),
    .overheat_warning(heat), .low_supply_warning(low),
    .power_switch_mode(switch_mode), .device_init(init),
    .normal_shutdown(shut), .interrupt_n(interrupt_n));

  bus_host host (.clock(clock), .sda_line(sda_line), .scl(scl),
    .sda_rel(sda_host));

  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic expect_reg(input string what, input logic [7:0] a,
                            input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    check(what, exp, d);
  endtask

  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // covers sync, filter and the 13-clock debounce
  task automatic settle();
    repeat (30) @(posedge clock);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_reset();
    check("int_n", 8'h01, {7'h00, interrupt_n});
    expect_reg("mask", EVENT_MASK_ADDR, EVENT_MASK_RESET);
    expect_reg("live", LIVE_STATUS_ADDR, 8'h00);
    expect_reg("latch", LATCH_FLAGS_ADDR, 8'h00);
    expect_reg("unmapped", 8'h05, READ_UNMAPPED);
  endtask

  task automatic test_live();
    en <= 4'hF;
    switch_mode <= 1'b1;
    pg <= 4'h5;
    btn_n <= 1'b0;
    settle();
    expect_reg("live", LIVE_STATUS_ADDR, 8'h45);
    btn_n <= 1'b1;
    pg <= 4'hF;
    host.write_reg(LIVE_STATUS_ADDR, 8'hFF);
    expect_reg("live ro", LIVE_STATUS_ADDR, 8'h0F);
  endtask

  task automatic test_events();
    heat <= 1'b1;
    low <= 1'b1;
    pg <= 4'h0;
    settle();
    heat <= 1'b0;
    low <= 1'b0;
    settle();
    expect_reg("events", EVENT_FLAGS_ADDR, 8'h7F);
    check("int_n", 8'h01, {7'h00, interrupt_n});
  endtask

  task automatic test_interrupt();
    host.write_reg(EVENT_MASK_ADDR, 8'h20);
    settle();
    check("int_n", 8'h00, {7'h00, interrupt_n});
    expect_reg("events", EVENT_FLAGS_ADDR, 8'h7F);
    host.write_reg(EVENT_FLAGS_ADDR, 8'h20);
    settle();
    check("int_n", 8'h01, {7'h00, interrupt_n});
    expect_reg("events", EVENT_FLAGS_ADDR, 8'h5F);
    expect_reg("mask", EVENT_MASK_ADDR, 8'h20);
  endtask

  task automatic test_suppress();
    host.write_reg(EVENT_FLAGS_ADDR, 8'h1F);
    pg <= 4'hF;
    settle();
    init <= 1'b1;
    pg <= 4'h0;
    settle();
    init <= 1'b0;
    pg <= 4'hF;
    settle();
    shut <= 1'b1;
    pg <= 4'h0;
    settle();
    shut <= 1'b0;
    expect_reg("events", EVENT_FLAGS_ADDR, 8'h40);
  endtask

  task automatic test_latch();
    thermal <= 1'b1;
    latchoff <= 4'h9;
    settle();
    expect_reg("latch", LATCH_FLAGS_ADDR, 8'h19);
    host.write_reg(LATCH_FLAGS_ADDR, 8'h1F);
    expect_reg("latch", LATCH_FLAGS_ADDR, 8'h19);
    thermal <= 1'b0;
    latchoff <= 4'h6;
    settle();
    latchoff <= 4'h0;
    expect_reg("latch", LATCH_FLAGS_ADDR, 8'h1F);
    host.write_reg(LATCH_FLAGS_ADDR, 8'h1F);
    expect_reg("latch", LATCH_FLAGS_ADDR, 8'h00);
  endtask

  task automatic test_enables();
    en <= 4'h0;
    settle();
    expect_reg("events", EVENT_FLAGS_ADDR, 8'h00);
    en <= 4'hF;
    pg <= 4'hF;
    switch_mode <= 1'b0;
    btn_n <= 1'b0;
    settle();
    expect_reg("live", LIVE_STATUS_ADDR, 8'h0F);
    expect_reg("events", EVENT_FLAGS_ADDR, 8'h00);
  endtask

  // ****************************************************************
  // clock, reset and sequence
  // ****************************************************************
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      stop_test();
    end
  end

  initial
  begin
    rst = 1'b1;
    pg = 4'h0;
    en = 4'h0;
    latchoff = 4'h0;
    btn_n = 1'b1;
    thermal = 1'b0;
    heat = 1'b0;
    low = 1'b0;
    switch_mode = 1'b0;
    init = 1'b0;
    shut = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    test_reset();
    test_live();
    test_events();
    test_interrupt();
    test_suppress();
    test_latch();
    test_enables();
    check("acks", 8'h00, 8'(host.ack_misses));
    stop_test();
  end
endmodule // testbench

`default_nettype wire
